// [src/vfdc_pkg.sv]
// shared constants for the fluorescent display controller
package vfdc_pkg;

  // clock and section timing
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned SECTION_NS     = 16000;
  localparam int unsigned SECTION_CYC    = (SECTION_NS * CLK_MHZ + 999) / 1000;
  localparam logic [10:0] SECTION_LAST   = 11'(SECTION_CYC - 1);

  // display scan layout
  localparam logic [4:0]  PWM_SECTIONS   = 5'h10;
  localparam logic [4:0]  KEY_SECTION    = 5'h10;
  localparam logic [4:0]  GRID_BASE      = 5'h08;
  localparam logic [4:0]  SEG_PLUS_GRID  = 5'h1c;
  localparam logic [3:0]  MODE_MAX       = 4'h8;
  localparam int unsigned RAM_DEPTH      = 48;
  localparam logic [5:0]  ADDR_LIMIT     = 6'h30;
  localparam logic [5:0]  NIBBLE_COL     = 6'h02;
  localparam logic [5:0]  BYTES_PER_GRID = 6'h03;

  // key matrix
  localparam int unsigned KEY_STROBES    = 12;
  localparam int unsigned KEY_RETURNS    = 4;
  localparam int unsigned KEY_BITS       = KEY_STROBES * KEY_RETURNS;
  localparam logic [4:0]  KEY_SLOTS      = 5'h0c;

  // command opcodes in bits 7:6 of a command byte
  localparam logic [1:0]  CMD_MODE       = 2'h0;
  localparam logic [1:0]  CMD_DATA       = 2'h1;
  localparam logic [1:0]  CMD_CTRL       = 2'h2;
  localparam logic [1:0]  CMD_ADDR       = 2'h3;

  // data setting modes in bits 1:0
  localparam logic [1:0]  DMODE_WR_DISP  = 2'h0;
  localparam logic [1:0]  DMODE_WR_LED   = 2'h1;
  localparam logic [1:0]  DMODE_RD_KEY   = 2'h2;
  localparam logic [1:0]  DMODE_RD_GIN   = 2'h3;

  // power-on values
  localparam logic [3:0]  RST_MODE       = 4'h8;
  localparam logic [1:0]  RST_DMODE      = 2'h0;
  localparam logic        RST_FIXED      = 1'b0;
  localparam logic [5:0]  RST_ADDR       = 6'h00;
  localparam logic [2:0]  RST_DIM        = 3'h0;
  localparam logic        RST_DISP_ON    = 1'b0;
  localparam logic [4:0]  RST_LED        = 5'h1f;

  // receive buffer and input synchronisers
  localparam int unsigned FIFO_WIDTH     = 9;
  localparam int unsigned FIFO_DEPTH     = 4;
  localparam int unsigned SYNC_BITS      = 11;

  // on-width in sixteenths for each brightness code
  function automatic logic [4:0] vfdc_dim_width(input logic [2:0] code);
    logic [4:0] w;
    w = 5'h01;
    unique case (code)
      3'h0: w = 5'h01;
      3'h1: w = 5'h02;
      3'h2: w = 5'h04;
      3'h3: w = 5'h0a;
      3'h4: w = 5'h0b;
      3'h5: w = 5'h0c;
      3'h6: w = 5'h0d;
      3'h7: w = 5'h0e;
    endcase
    return w;
  endfunction

endpackage

// [src/vfdc_fifo.sv]
// small valid/ready fifo between the serial receiver and the command executor
`timescale 1ns/1ns
module vfdc_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 4
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  // fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned PW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0]    cnt_q, cnt_d;
  logic             push, pop;

  assign in_ready_o  = (cnt_q != FULL_CNT);
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rd_q];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_comb begin
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      wr_d = (wr_q == LAST_PTR) ? '0 : wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = (rd_q == LAST_PTR) ? '0 : rd_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // storage holds no control state, so it needs no reset
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

endmodule

// [src/vfdc_top.sv]
// fluorescent display controller: serial link, display memory, dimming, key scan
//
// Contract
// - byte-addressed display memory, nibbles, mapped per grid
// - last four segment lines use low nibble only
// - grid period split into seventeen equal sections, sixteen pwm and one key
// - brightness code picks 1,2,4,10..14 sixteenths
// - twelve strobes sample four returns into storage
// - key read shifts stored states out lsb first
// - led write lsb first, zero lights led
// - led data bits five to seven dropped
// - input nibble read lsb first, upper zeros
// - first byte after select low is command
// - select high mid-byte discards partial byte only
// - mode change forces display off, stops scanning
// - same mode selected again does nothing
// - power-on mode sixteen grids twelve segments
// - power-on data setting normal, auto increment
// - address 30 hex or above drops data
// - power-on address pointer is zero
// - power-on dimmest width, display off, scan stopped
// - key scan cycle spans two display frames
`timescale 1ns/1ns
module vfdc_top
  import vfdc_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // serial link
  input  wire logic        cs_n_i,
  input  wire logic        sclk_i,
  input  wire logic        serial_data_in_i,
  output logic             dout_o,
  output logic             dout_oe_n_o,
  // key matrix and input port
  input  wire logic [3:0]  key_return_inputs_i,
  input  wire logic [3:0]  general_input_nibble_i,
  // display drive
  output logic [11:0]      segment_key_strobe_lines_o,
  output logic [7:0]       seg_upper_o,
  output logic [15:0]      grid_o,
  output logic [4:0]       led_o,
  // status
  output logic             display_on_o,
  output logic             rx_drop_o
);

  // input synchronisers
  logic [SYNC_BITS-1:0] sync1_q, sync2_q;
  logic                 sclk_prev_q;
  logic                 cs_n_s, sclk_s, din_s, rise, fall;
  logic [3:0]           keyret_s, gin_s;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync1_q     <= 11'h003;
      sync2_q     <= 11'h003;
      sclk_prev_q <= 1'b1; // link clock idles high, so no false rise
    end else begin
      sync1_q     <= {general_input_nibble_i, key_return_inputs_i, serial_data_in_i,
                      sclk_i, cs_n_i};
      sync2_q     <= sync1_q;
      sclk_prev_q <= sync2_q[1];
    end
  end

  assign cs_n_s   = sync2_q[0];
  assign sclk_s   = sync2_q[1];
  assign din_s    = sync2_q[2];
  assign keyret_s = sync2_q[6:3];
  assign gin_s    = sync2_q[10:7];
  assign rise     = sclk_s & ~sclk_prev_q;
  assign fall     = ~sclk_s & sclk_prev_q;

  // receiver and read-out shifter
  logic [7:0]          rx_sh_q, rx_sh_d;
  logic [2:0]          rx_cnt_q, rx_cnt_d;
  logic                first_q, first_d;
  logic                rd_phase_q, rd_phase_d;
  logic                arm_q, arm_d;
  logic [KEY_BITS-1:0] tx_sh_q, tx_sh_d;
  logic [KEY_BITS-1:0] key_q, key_d;
  logic                push_valid, push_ready;
  logic [8:0]          push_data;
  logic [7:0]          rx_byte;

  assign rx_byte = {din_s, rx_sh_q[7:1]};

  always_comb begin
    rx_sh_d    = rx_sh_q;
    rx_cnt_d   = rx_cnt_q;
    first_d    = first_q;
    rd_phase_d = rd_phase_q;
    arm_d      = arm_q;
    tx_sh_d    = tx_sh_q;
    push_valid = 1'b0;
    push_data  = {first_q, rx_byte};
    if (cs_n_s) begin
      // partial byte thrown away, executed state untouched
      rx_cnt_d   = 3'h0;
      first_d    = 1'b1;
      rd_phase_d = 1'b0;
      arm_d      = 1'b0;
    end else if (rd_phase_q) begin
      // host samples on rise, next bit shows after the following fall
      if (rise) begin
        arm_d = 1'b1;
      end
      if (fall && arm_q) begin
        tx_sh_d = {1'b1, tx_sh_q[KEY_BITS-1:1]};
        arm_d   = 1'b0;
      end
    end else if (rise) begin
      rx_sh_d  = rx_byte; // lsb first on rising edge
      rx_cnt_d = rx_cnt_q + 3'h1;
      if (rx_cnt_q == 3'h7) begin
        push_valid = 1'b1;
        first_d    = 1'b0; // only the first byte is a command
        if (first_q && rx_byte[7:6] == CMD_DATA && rx_byte[1]) begin
          rd_phase_d = 1'b1;
          if (rx_byte[1:0] == DMODE_RD_GIN) begin
            tx_sh_d = {40'hff_ffff_ffff, 4'h0, gin_s};
          end else begin
            tx_sh_d = key_q;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_sh_q    <= 8'h00;
      rx_cnt_q   <= 3'h0;
      first_q    <= 1'b1;
      rd_phase_q <= 1'b0;
      arm_q      <= 1'b0;
      tx_sh_q    <= {KEY_BITS{1'b1}};
    end else begin
      rx_sh_q    <= rx_sh_d;
      rx_cnt_q   <= rx_cnt_d;
      first_q    <= first_d;
      rd_phase_q <= rd_phase_d;
      arm_q      <= arm_d;
      tx_sh_q    <= tx_sh_d;
    end
  end

  // open drain: only ever pulls low
  assign dout_o      = 1'b0;
  assign dout_oe_n_o = ~(rd_phase_q & ~tx_sh_q[0]);
  // the link cannot be stalled, so a full buffer loses the byte
  assign rx_drop_o   = push_valid & ~push_ready;

  // receive buffer
  logic       ent_valid, ent_ready;
  logic [8:0] ent;

  vfdc_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (push_valid),
    .in_ready_o  (push_ready),
    .in_data_i   (push_data),
    .out_valid_o (ent_valid),
    .out_ready_i (ent_ready),
    .out_data_o  (ent)
  );

  // command executor, one entry every two cycles
  logic [7:0] ram_q [RAM_DEPTH];
  logic [3:0] mode_q, mode_d, new_mode;
  logic [1:0] dmode_q, dmode_d;
  logic       fixed_q, fixed_d;
  logic [5:0] addr_q, addr_d;
  logic       disp_on_q, disp_on_d;
  logic [2:0] dim_q, dim_d;
  logic [4:0] led_q, led_d;
  logic       busy_q, busy_d;
  logic       ram_we;
  logic [7:0] ram_wd;
  logic       pop;

  assign ent_ready = ~busy_q;
  assign pop       = ent_valid & ~busy_q;
  assign new_mode  = (ent[3:0] > MODE_MAX) ? MODE_MAX : ent[3:0];

  always_comb begin
    mode_d    = mode_q;
    dmode_d   = dmode_q;
    fixed_d   = fixed_q;
    addr_d    = addr_q;
    disp_on_d = disp_on_q;
    dim_d     = dim_q;
    led_d     = led_q;
    busy_d    = pop;
    ram_we    = 1'b0;
    ram_wd    = ent[7:0];
    if (pop && ent[8]) begin
      unique case (ent[7:6])
        CMD_MODE: begin
          if (new_mode != mode_q) begin
            mode_d    = new_mode;
            disp_on_d = 1'b0;
          end
        end
        CMD_DATA: begin
          dmode_d = ent[1:0];
          fixed_d = ent[2];
        end
        CMD_CTRL: begin
          dim_d     = ent[2:0];
          disp_on_d = ent[3];
        end
        CMD_ADDR: begin
          addr_d = ent[5:0];
        end
      endcase
    end else if (pop) begin
      if (dmode_q == DMODE_WR_DISP && addr_q < ADDR_LIMIT) begin
        ram_we = 1'b1;
        if ((addr_q % BYTES_PER_GRID) == NIBBLE_COL) begin
          ram_wd = {4'h0, ent[3:0]};
        end
        if (!fixed_q) begin
          addr_d = addr_q + 6'h01; // stops at the limit, never wraps back in
        end
      end else if (dmode_q == DMODE_WR_LED) begin
        led_d = ent[4:0];
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mode_q    <= RST_MODE;
      dmode_q   <= RST_DMODE;
      fixed_q   <= RST_FIXED;
      addr_q    <= RST_ADDR;
      disp_on_q <= RST_DISP_ON;
      dim_q     <= RST_DIM;
      led_q     <= RST_LED;
      busy_q    <= 1'b0;
    end else begin
      mode_q    <= mode_d;
      dmode_q   <= dmode_d;
      fixed_q   <= fixed_d;
      addr_q    <= addr_d;
      disp_on_q <= disp_on_d;
      dim_q     <= dim_d;
      led_q     <= led_d;
      busy_q    <= busy_d;
    end
  end

  // contents are undefined until written, as with any display memory
  always_ff @(posedge clk_i) begin
    if (ram_we) begin
      ram_q[addr_q] <= ram_wd;
    end
  end

  // scan timing and key storage
  logic [10:0] cyc_q, cyc_d;
  logic [4:0]  sect_q, sect_d;
  logic [3:0]  grid_q, grid_d;
  logic        odd_q, odd_d;
  logic [4:0]  grids, segs, slot;
  int unsigned kidx;

  assign grids = GRID_BASE + {1'b0, mode_q};
  assign segs  = SEG_PLUS_GRID - grids;
  assign slot  = odd_q ? grids + {1'b0, grid_q} : {1'b0, grid_q};
  assign kidx  = 32'(slot) * KEY_RETURNS;

  always_comb begin
    cyc_d  = cyc_q;
    sect_d = sect_q;
    grid_d = grid_q;
    odd_d  = odd_q;
    key_d  = key_q;
    if (!disp_on_q) begin
      // scanning halted, stored keys kept
      cyc_d  = 11'h000;
      sect_d = 5'h00;
      grid_d = 4'h0;
      odd_d  = 1'b0;
    end else if (cyc_q != SECTION_LAST) begin
      cyc_d = cyc_q + 11'h001;
    end else begin
      cyc_d  = 11'h000;
      sect_d = sect_q + 5'h01; // sixteen pwm sections then a key section
      if (sect_q == KEY_SECTION) begin
        sect_d = 5'h00;
        if (slot < KEY_SLOTS) begin
          key_d[kidx +: KEY_RETURNS] = keyret_s;
        end
        if ({1'b0, grid_q} == grids - 5'h01) begin
          grid_d = 4'h0;
          odd_d  = ~odd_q; // two frames per key cycle
        end else begin
          grid_d = grid_q + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cyc_q  <= 11'h000;
      sect_q <= 5'h00;
      grid_q <= 4'h0;
      odd_q  <= 1'b0;
      key_q  <= {KEY_BITS{1'b0}};
    end else begin
      cyc_q  <= cyc_d;
      sect_q <= sect_d;
      grid_q <= grid_d;
      odd_q  <= odd_d;
      key_q  <= key_d;
    end
  end

  // output drive
  logic [19:0] seg_q, seg_d;
  logic [15:0] grid_out_q, grid_out_d;
  logic [5:0]  base;
  logic        lit;

  assign base = {grid_q, 1'b0} + {2'b00, grid_q};
  assign lit  = disp_on_q && (sect_q < PWM_SECTIONS) &&
                (sect_q < vfdc_dim_width(dim_q));

  always_comb begin
    seg_d      = 20'h00000;
    grid_out_d = 16'h0000;
    if (lit) begin
      grid_out_d[grid_q] = 1'b1;
      seg_d = {ram_q[base + 6'h02][3:0], ram_q[base + 6'h01], ram_q[base]};
      for (int i = 0; i < 20; i++) begin
        if (5'(i) >= segs) begin
          seg_d[i] = 1'b0;
        end
      end
    end else if (disp_on_q && sect_q == KEY_SECTION && slot < KEY_SLOTS) begin
      seg_d[slot] = 1'b1; // strobe shares the low segment lines
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      seg_q      <= 20'h00000;
      grid_out_q <= 16'h0000;
    end else begin
      seg_q      <= seg_d;
      grid_out_q <= grid_out_d;
    end
  end

  assign segment_key_strobe_lines_o = seg_q[11:0];
  assign seg_upper_o                = seg_q[19:12];
  assign grid_o                     = grid_out_q;
  assign led_o                      = led_q;
  assign display_on_o               = disp_on_q;

endmodule

// [tb/vfdc_top_properties.sv]
// concurrent checks on the display controller ports
`timescale 1ns/1ns
module vfdc_top_properties
  import vfdc_pkg::*;
(
  // clock and reset
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  // serial link
  input wire logic        cs_n_i,
  input wire logic        sclk_i,
  input wire logic        serial_data_in_i,
  input wire logic        dout_o,
  input wire logic        dout_oe_n_o,
  // keys and input port
  input wire logic [3:0]  key_return_inputs_i,
  input wire logic [3:0]  general_input_nibble_i,
  // display drive and status
  input wire logic [11:0] segment_key_strobe_lines_o,
  input wire logic [7:0]  seg_upper_o,
  input wire logic [15:0] grid_o,
  input wire logic [4:0]  led_o,
  input wire logic        display_on_o,
  input wire logic        rx_drop_o
);
  logic [4:0]  cs_hi_d, cs_hi_q;
  logic [15:0] on_cnt_d, on_cnt_q;

  // idle select counter saturates so long pauses never wrap
  always_comb begin
    cs_hi_d  = cs_n_i ? ((cs_hi_q == 5'h1f) ? cs_hi_q : cs_hi_q + 5'h01) : 5'h00;
    on_cnt_d = (|grid_o) ? on_cnt_q + 16'h0001 : 16'h0000;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cs_hi_q  <= 5'h00;
      on_cnt_q <= 16'h0000;
    end else begin
      cs_hi_q  <= cs_hi_d;
      on_cnt_q <= on_cnt_d;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  a_grid_one_hot: assert property ($onehot0(grid_o))
    else $error("more than one grid driven");
  a_off_dark: assert property (!display_on_o [*3] |-> grid_o == 16'h0000)
    else $error("grid lit while display off");
  a_dim_width: assert property ($fell(|grid_o) && display_on_o && $past(display_on_o, 2)
    |-> on_cnt_q % SECTION_CYC == 0 && (on_cnt_q / SECTION_CYC) inside {1, 2, 4, [10:14]})
    else $error("grid on-width not a legal dimming step");
  a_read_idle: assert property (cs_n_i [*6] |-> dout_oe_n_o)
    else $error("read line driven outside a frame");
  a_read_level: assert property (!dout_oe_n_o |-> dout_o == 1'b0 && $past(!cs_n_i, 3))
    else $error("read line driven high or outside a frame");
  a_led_quiet: assert property (cs_hi_q >= 5'h14 |-> $stable(led_o) && $stable(display_on_o))
    else $error("settings changed with no frame");
  a_on_by_cmd: assert property ($rose(display_on_o) |-> cs_hi_q < 5'h14)
    else $error("display turned on without a command");
  a_reset_vals: assert property ($fell(sys_rst_i) |-> led_o == 5'h1f && !display_on_o)
    else $error("wrong state after reset");

  c_lit: cover property ($rose(display_on_o));
  c_wide: cover property ($fell(|grid_o) && on_cnt_q == 16'(14 * SECTION_CYC));
  c_led: cover property ($changed(led_o));
endmodule

bind vfdc_top vfdc_top_properties vfdc_top_properties_i (.clk_i, .sys_rst_i, .cs_n_i, .sclk_i,
  .serial_data_in_i, .dout_o, .dout_oe_n_o, .key_return_inputs_i, .general_input_nibble_i,
  .segment_key_strobe_lines_o, .seg_upper_o, .grid_o, .led_o, .display_on_o, .rx_drop_o);

// [tb/vfdc_host_model.sv]
// host side of the serial link: frames, byte writes and reads
`timescale 1ns/1ns
module vfdc_host_model (
  // link outputs
  output logic      cs_n_o,
  output logic      sclk_o,
  output logic      din_o,
  // read-back line
  input  wire logic dout_i
);
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b1;
    din_o  = 1'b0;
  end

  // the first byte after this is always a command
  task automatic start();
    cs_n_o <= 1'b0;
    #200;
  endtask

  // data moves only while the clock is low
  task automatic put(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      sclk_o <= 1'b0;
      din_o  <= b[i];
      #62;
      sclk_o <= 1'b1;
      #63;
    end
  endtask

  task automatic get(output logic [7:0] b);
    #1000;
    for (int i = 0; i < 8; i++) begin
      sclk_o <= 1'b0;
      #62;
      sclk_o <= 1'b1;
      #62;
      b[i] = dout_i;
      #1;
    end
  endtask

  // clock-to-select gap, then the data line stops holding its last value
  task automatic stop();
    #1000;
    cs_n_o <= 1'b1;
    din_o  <= ~din_o;
    #500;
  endtask
endmodule

// [tb/tb.sv]
// self-checking bench for the display controller
`timescale 1ns/1ns
module tb
  import vfdc_pkg::*;
;
  typedef struct packed {
    logic [7:0] led_byte;
    logic [4:0] led_exp;
    logic [3:0] nib;
  } vfdc_row_t;

  logic        clk_i, sys_rst_i, cs_n_i, sclk_i, serial_data_in_i, dout_o, dout_oe_n_o;
  logic        display_on_o, rx_drop_o;
  logic [3:0]  key_return_inputs_i, general_input_nibble_i;
  logic [11:0] segment_key_strobe_lines_o;
  logic [7:0]  seg_upper_o, rb;
  logic [15:0] grid_o;
  logic [4:0]  led_o;
  wire         dout_w;
  int          mismatches, samples_checked;
  vfdc_row_t   rows [3] = '{'{8'hea, 5'h0a, 4'h5}, '{8'h15, 5'h15, 4'ha}, '{8'hf3, 5'h13, 4'hf}};

  // pull-up on the shared read line
  assign dout_w = dout_oe_n_o ? 1'b1 : dout_o;

  vfdc_top vfdc_top_i (.clk_i, .sys_rst_i, .cs_n_i, .sclk_i, .serial_data_in_i, .dout_o,
    .dout_oe_n_o, .key_return_inputs_i, .general_input_nibble_i, .segment_key_strobe_lines_o,
    .seg_upper_o, .grid_o, .led_o, .display_on_o, .rx_drop_o);

  vfdc_host_model vfdc_host_model_i (.cs_n_o(cs_n_i), .sclk_o(sclk_i),
    .din_o(serial_data_in_i), .dout_i(dout_w));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic chk_bits(input string nm, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk_count(input string nm, input int exp, input int got);
    samples_checked++;
    if (got != exp) begin
      mismatches++;
      $display("unexpected %s: expected %0d seen %0d", nm, exp, got);
    end
  endtask

  task automatic send(input logic [7:0] c, input logic [7:0] d, input int n);
    vfdc_host_model_i.start();
    vfdc_host_model_i.put(c, 8);
    if (n > 1) vfdc_host_model_i.put(d, 8);
    vfdc_host_model_i.stop();
  endtask

  task automatic fetch(input logic [7:0] c, output logic [7:0] b);
    vfdc_host_model_i.start();
    vfdc_host_model_i.put(c, 8);
    vfdc_host_model_i.get(b);
    vfdc_host_model_i.stop();
  endtask

  // started beside the display-on frame so the first slot is seen whole
  task automatic measure(input int sec, input logic [19:0] seg);
    int n;
    int t;
    t = 0;
    n = 0;
    while (grid_o === 16'h0000 && t < 30000) begin
      @(negedge clk_i);
      t++;
    end
    while (grid_o !== 16'h0000 && n < 30000) begin
      if (n == 2) begin
        chk_bits("segments", {4'h0, seg[11:0]}, {4'h0, segment_key_strobe_lines_o});
        chk_bits("upper segments", {8'h00, seg[19:12]}, {8'h00, seg_upper_o});
        chk_bits("grid", 16'h0001, grid_o);
      end
      n++;
      @(negedge clk_i);
    end
    chk_count("on width", sec * SECTION_CYC, n);
  endtask

  task automatic summarize();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #700000;
    mismatches++;
    summarize();
  end

  initial begin
    sys_rst_i = 1'b1;
    key_return_inputs_i = 4'h0;
    general_input_nibble_i = 4'h0;
    mismatches = 0;
    samples_checked = 0;
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(negedge clk_i);
    chk_bits("led", 16'h001f, {11'h0, led_o});
    chk_bits("display on", 16'h0000, {15'h0, display_on_o});
    chk_bits("read enable", 16'h0001, {15'h0, dout_oe_n_o});
    // bulk refresh: mode, data setting, address with data, control later
    send(8'h08, 8'h00, 1);
    send(8'h40, 8'h00, 1);
    vfdc_host_model_i.start();
    vfdc_host_model_i.put(8'hc0, 8);
    vfdc_host_model_i.put(8'h5a, 8);
    vfdc_host_model_i.put(8'h3c, 8);
    vfdc_host_model_i.stop();
    foreach (rows[i]) begin
      send(8'h41, rows[i].led_byte, 2);
      chk_bits("led", {11'h0, rows[i].led_exp}, {11'h0, led_o});
      @(posedge clk_i);
      general_input_nibble_i <= rows[i].nib;
      fetch(8'h43, rb);
      chk_bits("input nibble", {12'h000, rows[i].nib}, {8'h00, rb});
    end
    // aborted byte must leave the last led value alone
    vfdc_host_model_i.start();
    vfdc_host_model_i.put(8'h41, 8);
    vfdc_host_model_i.put(8'h00, 4);
    vfdc_host_model_i.stop();
    chk_bits("led", 16'h0013, {11'h0, led_o});
    @(posedge clk_i);
    key_return_inputs_i <= 4'h9;
    fork
      send(8'h8f, 8'h00, 1);
      measure(14, 20'h00c5a);
    join
    // mid key section of slot zero, then past its latch but short of slot one
    repeat (4000) @(negedge clk_i);
    chk_bits("strobe", 16'h0001, {4'h0, segment_key_strobe_lines_o});
    repeat (2000) @(posedge clk_i);
    send(8'h80, 8'h00, 1);
    fetch(8'h42, rb);
    chk_bits("key byte", 16'h0009, {8'h00, rb});
    fork
      send(8'h88, 8'h00, 1);
      measure(1, 20'h00c5a);
    join
    send(8'h08, 8'h00, 1);
    chk_bits("display on", 16'h0001, {15'h0, display_on_o});
    send(8'h00, 8'h00, 1);
    chk_bits("display on", 16'h0000, {15'h0, display_on_o});
    // eight grids open the upper lines; single update of the last column
    send(8'h40, 8'h00, 1);
    send(8'hc2, 8'hff, 2);
    fork
      send(8'h88, 8'h00, 1);
      measure(1, 20'hf3c5a);
    join
    // mid-run reset: mode and pointer go back to power-on values
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(negedge clk_i);
    chk_bits("led", 16'h001f, {11'h0, led_o});
    chk_bits("display on", 16'h0000, {15'h0, display_on_o});
    send(8'h40, 8'ha5, 2);
    fork
      send(8'h88, 8'h00, 1);
      measure(1, 20'h00ca5);
    join
    summarize();
  end
endmodule
